// [hdl/rgbscp_params.svh]
// Constants for the three-channel LED serial control port.
// Assumes inclusion by bare name from package and modules alike.
`ifndef RGBSCP_PARAMS_SVH
`define RGBSCP_PARAMS_SVH

`define RGBSCP_FRAME_BITS    16
`define RGBSCP_CNT_W         5
`define RGBSCP_ADDR_RED      8'h01
`define RGBSCP_ADDR_GREEN    8'h02
`define RGBSCP_ADDR_BLUE     8'h03
`define RGBSCP_CHAN_RESET    8'h00
`define RGBSCP_EN_BIT        5
`define RGBSCP_CODE_MSB      4
`define RGBSCP_DATA_W        8
`define RGBSCP_NUM_CHAN      3
`define RGBSCP_NUM_PINS      8
`define RGBSCP_CLK_PERIOD_NS 10
// Shift clock period in ns; at least 330 ns, 500 ns gives 2 MHz.
`define RGBSCP_SCLK_PERIOD_NS 500
`define RGBSCP_SCLK_HALF_CYC ((`RGBSCP_SCLK_PERIOD_NS + 2*`RGBSCP_CLK_PERIOD_NS - 1) / (2*`RGBSCP_CLK_PERIOD_NS))
`define RGBSCP_STARTUP_NS    2000
`define RGBSCP_STARTUP_CYC   ((`RGBSCP_STARTUP_NS + `RGBSCP_CLK_PERIOD_NS - 1) / `RGBSCP_CLK_PERIOD_NS)
`define RGBSCP_HDIV_W        8
`define RGBSCP_WAIT_W        9
`define RGBSCP_REG_SEND      2'h0
`define RGBSCP_REG_STANDBY   2'h1
`define RGBSCP_REG_STATUS    2'h2

`endif

// [hdl/rgbscp_pkg.sv]
// Types shared by both ends of the LED serial control port.
// Assumes rgbscp_params.svh is on the include path.
`include "rgbscp_params.svh"

package rgbscp_pkg;
  typedef logic [`RGBSCP_FRAME_BITS-1:0] rgbscp_frame_t;
  typedef logic [7:0]                    rgbscp_byte_t;
  typedef enum logic [1:0] {RGBSCP_IDLE, RGBSCP_SHIFT, RGBSCP_GAP, RGBSCP_WAIT} rgbscp_hstate_t;
endpackage : rgbscp_pkg

// [hdl/rgbscp_if.sv]
// Link wires between the host controller and the LED driver port.
// Assumes both ends run on the same mclk domain; the shift clock is a plain wire.
`timescale 1ns/1ps
`default_nettype none

interface rgbscp_if;
  logic sclk;
  logic serial_in;
  logic frame_sel;
  logic standby_request_a;
  logic standby_request_b;

  modport host (
    output sclk,
    output serial_in,
    output frame_sel,
    output standby_request_a,
    output standby_request_b
  );
  modport device (
    input sclk,
    input serial_in,
    input frame_sel,
    input standby_request_a,
    input standby_request_b
  );
endinterface : rgbscp_if

`default_nettype wire

// [hdl/rgbscp_sync.sv]
// Two-flop synchroniser, one per bit, for link pins entering mclk.
// Assumes the inputs are asynchronous levels.
`timescale 1ns/1ps
`default_nettype none

module rgbscp_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  import rgbscp_pkg::*;

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } rgbscp_sync_state_t;

  rgbscp_sync_state_t state_q;
  rgbscp_sync_state_t state_d;

  always_comb begin
    state_d      = state_q;
    state_d.meta = async_i;
    state_d.sync = state_q.meta;
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign sync_o = state_q.sync;
endmodule : rgbscp_sync

`default_nettype wire

// [hdl/rgbscp_device.sv]
// LED driver end: receives 16-bit frames on the three-wire link, holds the
// red, green and blue channel settings and gates the three outputs.
// Assumes every link pin and gate pin is asynchronous to mclk and that the
// shift clock levels last at least three mclk cycles, so that the two-flop
// synchroniser can see each of them.
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "rgbscp_params.svh"

module rgbscp_device (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  rgbscp_if.device         link,
  input  wire logic        red_gate_input_i,
  input  wire logic        green_gate_input_i,
  input  wire logic        blue_gate_input_i,
  output logic             red_output_o,
  output logic             green_output_o,
  output logic             blue_output_o,
  output logic [4:0]       red_code_o,
  output logic [4:0]       green_code_o,
  output logic [4:0]       blue_code_o,
  output logic             standby_o
);
  import rgbscp_pkg::*;

  // ----------------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------------
  // All link and gate pins pass the same two flops. Equal delay keeps the
  // data line in step with the shift clock, so sampling on the synchronised
  // edge sees the bit that stood at the pin when the clock rose.
  // The gate pins are levels from elsewhere on the board, so they are
  // treated the same way although nothing about them is timed.
  logic [`RGBSCP_NUM_PINS-1:0] pins_a;
  logic [`RGBSCP_NUM_PINS-1:0] pins_s;

  assign pins_a = {link.sclk,
                   link.serial_in,
                   link.frame_sel,
                   link.standby_request_a,
                   link.standby_request_b,
                   blue_gate_input_i,
                   green_gate_input_i,
                   red_gate_input_i};

  rgbscp_sync #(
    .W (`RGBSCP_NUM_PINS)
  ) u_sync (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .async_i (pins_a),
    .sync_o  (pins_s)
  );

  logic                        sclk_s;
  logic                        sdi_s;
  logic                        sel_s;
  logic                        sba_s;
  logic                        sbb_s;
  logic [`RGBSCP_NUM_CHAN-1:0] gate_s;

  // The red gate lands in bit zero, which matches the channel index below.
  assign {sclk_s, sdi_s, sel_s, sba_s, sbb_s, gate_s} = pins_s;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic                                sclk_prev;
    logic                                sel_prev;
    logic [`RGBSCP_CNT_W-1:0]            count;
    rgbscp_frame_t                       shift;
    rgbscp_byte_t [`RGBSCP_NUM_CHAN-1:0] chan;
    logic [`RGBSCP_NUM_CHAN-1:0]         outs;
    logic                                standby;
  } rgbscp_dev_state_t;

  rgbscp_dev_state_t state_q;
  rgbscp_dev_state_t state_d;

  // ----------------------------------------------------------------------
  // Link edges
  // ----------------------------------------------------------------------
  // The previous levels reset to the idle levels of the pins, clock low and
  // select low, so no false edge follows the release of reset. Data is
  // taken on the synchronised rising edge of the shift clock only.
  logic sclk_rise;
  logic sel_fall;
  logic shift_open;

  assign sclk_rise  = sclk_s && !state_q.sclk_prev;
  assign sel_fall   = !sel_s && state_q.sel_prev;
  // Bits past the sixteenth are kept out by closing the shifter, so the
  // first sixteen bits of an overlong frame are the ones that survive.
  assign shift_open = state_q.count < `RGBSCP_CNT_W'(`RGBSCP_FRAME_BITS);

  // ----------------------------------------------------------------------
  // Frame fields
  // ----------------------------------------------------------------------
  // Address bit seven arrives first, so after sixteen shifts the address
  // sits in the upper byte and data bit zero in the lowest bit.
  rgbscp_byte_t frame_addr;
  rgbscp_byte_t frame_data;
  logic         frame_full;
  logic         commit;

  assign frame_addr = state_q.shift[`RGBSCP_FRAME_BITS-1 -: `RGBSCP_DATA_W];
  assign frame_data = state_q.shift[`RGBSCP_DATA_W-1:0];
  // A select fall after a short count commits nothing.
  assign frame_full = state_q.count == `RGBSCP_CNT_W'(`RGBSCP_FRAME_BITS);
  assign commit     = sel_fall && frame_full;

  // ----------------------------------------------------------------------
  // Channel decode
  // ----------------------------------------------------------------------
  // Each channel owns one address. A frame for any other address hits no
  // channel and so leaves every setting as it was.
  localparam rgbscp_byte_t CHAN_ADDR [`RGBSCP_NUM_CHAN] = '{
    `RGBSCP_ADDR_RED,
    `RGBSCP_ADDR_GREEN,
    `RGBSCP_ADDR_BLUE
  };

  logic [`RGBSCP_NUM_CHAN-1:0]         chan_hit;
  logic [`RGBSCP_NUM_CHAN-1:0]         chan_lit;
  rgbscp_byte_t [`RGBSCP_NUM_CHAN-1:0] chan_nxt;

  for (genvar i = 0; i < `RGBSCP_NUM_CHAN; i++) begin : g_chan
    assign chan_hit[i] = commit && (frame_addr == CHAN_ADDR[i]);
    // A write to one channel passes the other two through untouched.
    assign chan_nxt[i] = chan_hit[i] ? frame_data : state_q.chan[i];
    // The gate passes light only through a channel that software enabled.
    assign chan_lit[i] = state_q.chan[i][`RGBSCP_EN_BIT] && gate_s[i];
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // Shifting and standby are decided in this process; it takes commit and gating from the channel decode.
  always_comb begin
    state_d           = state_q;
    state_d.sclk_prev = sclk_s;
    state_d.sel_prev  = sel_s;
    if (sel_s && sclk_rise && shift_open) begin
      state_d.shift = {state_q.shift[`RGBSCP_FRAME_BITS-2:0], sdi_s};
      state_d.count = state_q.count + `RGBSCP_CNT_W'(1);
    end
    // The count restarts whenever select is low, so a short frame leaves no
    // bits behind for the next frame to complete.
    if (!sel_s) begin
      state_d.count = '0;
    end
    state_d.chan    = chan_nxt;
    state_d.standby = !sba_s && !sbb_s;
    // Standby forces the outputs off too, so a lit channel never outlives
    // the request for standby.
    state_d.outs    = state_d.standby ? '0 : chan_lit;
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Reset clears every channel, which leaves all outputs off until software
  // enables a channel.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_q      <= '0;
      state_q.chan <= {`RGBSCP_NUM_CHAN{`RGBSCP_CHAN_RESET}};
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Only the current code leaves the block; the enable bit acts solely
  // through the gated outputs.
  assign red_output_o   = state_q.outs[0];
  assign green_output_o = state_q.outs[1];
  assign blue_output_o  = state_q.outs[2];
  assign red_code_o     = state_q.chan[0][`RGBSCP_CODE_MSB:0];
  assign green_code_o   = state_q.chan[1][`RGBSCP_CODE_MSB:0];
  assign blue_code_o    = state_q.chan[2][`RGBSCP_CODE_MSB:0];
  // The standby flag trails the pins by three cycles: two flops, one register.
  assign standby_o      = state_q.standby;
endmodule : rgbscp_device

`default_nettype wire

// [hdl/rgbscp_host.sv]
// Host controller end: software registers on a plain strobe port; sends
// 16-bit frames and drives the standby requests. Assumes mclk of 100 MHz.
`timescale 1ns/1ps
`default_nettype none
`include "rgbscp_params.svh"

module rgbscp_host (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  rgbscp_if.host           link,
  input  wire logic [1:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o
);
  import rgbscp_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    rgbscp_hstate_t           st;
    rgbscp_frame_t            shift;
    logic [`RGBSCP_CNT_W-1:0] bits;
    logic [`RGBSCP_HDIV_W-1:0] div;
    logic [`RGBSCP_WAIT_W-1:0] wait_cnt;
    logic                     sclk;
    logic                     sel;
    logic                     release_req;
    logic                     standby_rel;
    logic                     frames_done;
    logic [15:0]              rdata;
  } rgbscp_host_state_t;

  rgbscp_host_state_t state_q;
  rgbscp_host_state_t state_d;
  logic               busy;

  assign busy = (state_q.st != RGBSCP_IDLE);

  always_comb begin
    state_d       = state_q;
    state_d.rdata = '0;
    if (rd_i && addr_i == `RGBSCP_REG_STATUS) begin
      state_d.rdata = {13'h0000, state_q.frames_done, state_q.standby_rel, busy};
    end
    if (wr_i && addr_i == `RGBSCP_REG_STANDBY) begin
      // Release is deferred until the startup wait after the last frame.
      state_d.release_req = wdata_i[0];
      if (!wdata_i[0]) begin
        state_d.standby_rel = 1'b0;
      end
    end
    case (state_q.st)
      RGBSCP_IDLE: begin
        if (wr_i && addr_i == `RGBSCP_REG_SEND) begin
          state_d.shift = wdata_i;
          state_d.bits  = '0;
          state_d.div   = '0;
          state_d.sel   = 1'b1;
          state_d.sclk  = 1'b0;
          state_d.st    = RGBSCP_SHIFT;
        end else if (state_d.release_req && state_q.frames_done &&
                     !state_q.standby_rel) begin
          // Following the written value lets a write of zero beat a release
          // that would otherwise fall due in the same cycle.
          state_d.standby_rel = 1'b1;
        end
      end
      RGBSCP_SHIFT: begin
        if (state_q.div == `RGBSCP_HDIV_W'(`RGBSCP_SCLK_HALF_CYC - 1)) begin
          state_d.div = '0;
          if (!state_q.sclk) begin
            state_d.sclk = 1'b1;
          end else begin
            state_d.sclk  = 1'b0;
            state_d.shift = {state_q.shift[`RGBSCP_FRAME_BITS-2:0], 1'b0};
            state_d.bits  = state_q.bits + `RGBSCP_CNT_W'(1);
            if (state_q.bits == `RGBSCP_CNT_W'(`RGBSCP_FRAME_BITS - 1)) begin
              state_d.st = RGBSCP_GAP;
            end
          end
        end else begin
          state_d.div = state_q.div + `RGBSCP_HDIV_W'(1);
        end
      end
      RGBSCP_GAP: begin
        if (state_q.div == `RGBSCP_HDIV_W'(`RGBSCP_SCLK_HALF_CYC - 1)) begin
          state_d.div      = '0;
          state_d.sel      = 1'b0;
          state_d.wait_cnt = '0;
          state_d.st       = RGBSCP_WAIT;
        end else begin
          state_d.div = state_q.div + `RGBSCP_HDIV_W'(1);
        end
      end
      RGBSCP_WAIT: begin
        if (state_q.wait_cnt == `RGBSCP_WAIT_W'(`RGBSCP_STARTUP_CYC - 1)) begin
          state_d.frames_done = 1'b1;
          state_d.st          = RGBSCP_IDLE;
        end else begin
          state_d.wait_cnt = state_q.wait_cnt + `RGBSCP_WAIT_W'(1);
        end
      end
      default: state_d.st = RGBSCP_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign link.sclk              = state_q.sclk;
  // The shifter empties to zero, so the data line rests low between frames.
  assign link.serial_in         = state_q.shift[`RGBSCP_FRAME_BITS-1];
  assign link.frame_sel         = state_q.sel;
  assign link.standby_request_a = state_q.standby_rel;
  assign link.standby_request_b = state_q.standby_rel;
  assign rdata_o                = state_q.rdata;
endmodule : rgbscp_host

`default_nettype wire

// [testbench/rgbscp_chk.sv]
// Checks of the link wires that the host end drives toward the LED driver.
// Assumes it sits beside the interface, sampled on mclk_i.
`timescale 1ns/1ps
`default_nettype none

module rgbscp_chk (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic sclk,
  input wire logic serial_in,
  input wire logic frame_sel,
  input wire logic standby_request_a,
  input wire logic standby_request_b
);
  logic sclk_q;
  logic sent_q;
  int   run_q;
  int   nclk_q;
  int   gap_q;

  // ----
  // Helper counters
  // ----
  // The gap starts saturated so the first frame after reset needs no wait.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      sclk_q <= 1'b0;
      sent_q <= 1'b0;
      run_q  <= 0;
      nclk_q <= 0;
      gap_q  <= 1000;
    end else begin
      sclk_q <= sclk;
      sent_q <= sent_q | (!frame_sel && nclk_q == 16);
      run_q  <= (sclk != sclk_q) ? 1 : run_q + 1;
      nclk_q <= !frame_sel ? 0 : nclk_q + int'(sclk && !sclk_q);
      gap_q  <= frame_sel ? 0 : (gap_q < 1000 ? gap_q + 1 : gap_q);
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  // ----
  // Link properties
  // ----
  sclk_level_a: assert property ($changed(sclk) |-> run_q >= 15)
    else $error("shift clock level too short");
  data_setup_a: assert property ($rose(sclk) |-> $past(serial_in, 10) == serial_in)
    else $error("data moved before shift clock rise");
  data_hold_a: assert property ($rose(sclk) |=> $stable(serial_in)[*8])
    else $error("data moved after shift clock rise");
  sclk_idle_a: assert property (!frame_sel |-> !sclk)
    else $error("shift clock high outside a frame");
  bit_count_a: assert property ($fell(frame_sel) |-> nclk_q == 16)
    else $error("frame without sixteen clocks");
  sel_setup_a: assert property ($rose(sclk) |-> $past(frame_sel, 15))
    else $error("select raised too late");
  sel_gap_a: assert property ($rose(frame_sel) |-> gap_q >= 100)
    else $error("select low time too short");
  release_order_a: assert property ($rose(standby_request_a) |-> sent_q && gap_q >= 200)
    else $error("standby released too early");
  standby_pair_a: assert property (standby_request_a == standby_request_b)
    else $error("standby requests differ");
endmodule : rgbscp_chk

`default_nettype wire

// [testbench/tb_top.sv]
// Bench: host drives driver A; the bench drives driver B with frames of 15 to 20 bits.
// Assumes the hdl files and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "rgbscp_params.svh"

module tb_top;
  import rgbscp_pkg::*;
  logic        mclk_i;
  logic        rst_n_i;
  logic [1:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic [2:0]  gate;
  logic [2:0]  o1;
  logic [2:0]  o2;
  logic [4:0]  c1 [3];
  logic [4:0]  c2 [3];
  logic        sb1;
  logic        sb2;
  int          error_cnt = 0;
  int          cmp_count = 0;

  rgbscp_if link1 ();
  rgbscp_if link2 ();
  rgbscp_host rgbscp_host_i (.mclk_i, .rst_n_i, .link(link1), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata));
  rgbscp_device rgbscp_device_i (.mclk_i, .rst_n_i, .link(link1),
    .red_gate_input_i(gate[0]), .green_gate_input_i(gate[1]), .blue_gate_input_i(gate[2]),
    .red_output_o(o1[0]), .green_output_o(o1[1]), .blue_output_o(o1[2]),
    .red_code_o(c1[0]), .green_code_o(c1[1]), .blue_code_o(c1[2]), .standby_o(sb1));
  rgbscp_device rgbscp_device_b_i (.mclk_i, .rst_n_i, .link(link2),
    .red_gate_input_i(gate[0]), .green_gate_input_i(gate[1]), .blue_gate_input_i(gate[2]),
    .red_output_o(o2[0]), .green_output_o(o2[1]), .blue_output_o(o2[2]),
    .red_code_o(c2[0]), .green_code_o(c2[1]), .blue_code_o(c2[2]), .standby_o(sb2));
  rgbscp_chk rgbscp_chk_i (.mclk_i, .rst_n_i, .sclk(link1.sclk), .serial_in(link1.serial_in),
    .frame_sel(link1.frame_sel), .standby_request_a(link1.standby_request_a),
    .standby_request_b(link1.standby_request_b));

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // ----
  // Access tasks
  // ----
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic wreg(input logic [1:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk_i);
    wr    <= 1'b0;
  endtask : wreg

  task automatic rreg(input logic [1:0] a, output logic [15:0] d);
    @(posedge mclk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk_i);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask : rreg

  task automatic send(input rgbscp_frame_t f);
    logic [15:0] s;
    wreg(`RGBSCP_REG_SEND, f);
    for (int i = 0; i < 1000; i++) begin
      rreg(`RGBSCP_REG_STATUS, s);
      if (s[0] === 1'b0) break;
    end
    chk("busy", s[0], 0);
  endtask : send

  // Shift clock of 125 ns on average: low 6 or 7 cycles, high 6 cycles.
  task automatic bang(input rgbscp_frame_t f, input int n);
    @(posedge mclk_i);
    link2.frame_sel <= 1'b1;
    repeat (15) @(posedge mclk_i);
    for (int i = 0; i < n; i++) begin
      link2.serial_in <= (i < 16) ? f[15-i] : i[0];
      repeat (6 + i % 2) @(posedge mclk_i);
      link2.sclk <= 1'b1;
      repeat (6) @(posedge mclk_i);
      link2.sclk <= 1'b0;
    end
    repeat (30) @(posedge mclk_i);
    link2.frame_sel <= 1'b0;
    link2.serial_in <= ~link2.serial_in;
    repeat (100) @(posedge mclk_i);
  endtask : bang

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #500us;
    error_cnt++;
    wrap_up();
  end

  // ----
  // Tests
  // ----
  initial begin
    logic [15:0] s;
    logic [7:0]  dat [3] = '{8'hE5, 8'h1F, 8'h20};
    logic [7:0]  bad [3] = '{8'h04, 8'h80, 8'h00};
    logic [15:0] fr [4] = '{16'h01EA, 16'h023F, 16'h0333, 16'h0211};
    int          nb [4] = '{16, 15, 20, 17};
    int          ix [4] = '{0, 1, 2, 1};
    logic [4:0]  ex [4] = '{5'h0A, 5'h00, 5'h13, 5'h11};
    rst_n_i = 1'b0;
    addr = 2'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    gate = 3'h0;
    link2.sclk = 1'b0;
    link2.serial_in = 1'b0;
    link2.frame_sel = 1'b0;
    link2.standby_request_a = 1'b0;
    link2.standby_request_b = 1'b0;
    repeat (10) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (5) @(posedge mclk_i);
    for (int k = 0; k < 3; k++) chk("code", c1[k], 0);
    chk("outs", o1, 0);
    chk("standby", sb1, 1);
    $display("test reset done");
    for (int k = 0; k < 3; k++) begin
      send({8'(k + 1), dat[k]});
      for (int j = 0; j < 3; j++) chk("code", c1[j], j <= k ? dat[j][4:0] : 5'h00);
    end
    for (int k = 0; k < 3; k++) begin
      send({bad[k], 8'hFF});
      for (int j = 0; j < 3; j++) chk("code", c1[j], dat[j][4:0]);
    end
    $display("test channel writes done");
    wreg(`RGBSCP_REG_STANDBY, 16'h0001);
    repeat (8) @(posedge mclk_i);
    chk("standby", sb1, 0);
    rreg(`RGBSCP_REG_STATUS, s);
    chk("status", s[2:1], 2'h3);
    gate <= 3'h7;
    repeat (8) @(posedge mclk_i);
    chk("outs", o1, 3'h5);
    gate <= 3'h6;
    repeat (8) @(posedge mclk_i);
    chk("outs", o1, 3'h4);
    wreg(`RGBSCP_REG_STANDBY, 16'h0000);
    repeat (8) @(posedge mclk_i);
    chk("standby", sb1, 1);
    $display("test gating done");
    for (int v = 0; v < 4; v++) begin
      link2.standby_request_a <= v[0];
      link2.standby_request_b <= v[1];
      repeat (8) @(posedge mclk_i);
      chk("standby b", sb2, v == 0);
    end
    gate <= 3'h7;
    for (int k = 0; k < 4; k++) begin
      bang(fr[k], nb[k]);
      chk("code b", c2[ix[k]], ex[k]);
    end
    chk("outs b", o2, 3'h5);
    $display("test frame length done");
    wrap_up();
  end
endmodule : tb_top

`default_nettype wire
